//--- logic/mode_select_pkg.sv
// constants and types for the per-channel interface mode selector
// assumes one clock domain; configuration memory words arrive already fetched
package mode_select_pkg;

   // channel interface modes
   typedef enum logic [3:0] {
      MODE_ASYNC_SERIAL = 4'h0,
      MODE_ASYNC_FIFO   = 4'h1,
      MODE_SYNC_FIFO    = 4'h2,
      MODE_FAST_SERIAL  = 4'h3,
      MODE_CPU_FIFO     = 4'h4,
      MODE_ASYNC_BANG   = 4'h5,
      MODE_SYNC_BANG    = 4'h6,
      MODE_SERIAL_ENG   = 4'h7,
      MODE_HOST_BUS_EMU = 4'h8
   } chan_mode_t;

   // configuration memory base-mode codes (low bits of the per-channel word)
   localparam logic [1:0] CFG_ASYNC_SERIAL = 2'h0;
   localparam logic [1:0] CFG_ASYNC_FIFO   = 2'h1;
   localparam logic [1:0] CFG_CPU_FIFO     = 2'h2;
   localparam logic [1:0] CFG_FAST_SERIAL  = 2'h3;
   localparam int         CFG_SYNC_BIT     = 2;

   // mode-switch command values
   localparam logic [7:0] CMD_RESET_MODE   = 8'h00;
   localparam logic [7:0] CMD_ASYNC_BANG   = 8'h01;
   localparam logic [7:0] CMD_SERIAL_ENG   = 8'h02;
   localparam logic [7:0] CMD_SYNC_BANG    = 8'h04;
   localparam logic [7:0] CMD_HOST_BUS_EMU = 8'h08;
   localparam logic [7:0] CMD_SYNC_FIFO    = 8'h40;

   // register map (word index * 4)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_CMD    = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_DIRB   = 4'hc;

   localparam int CTRL_ENUM_BIT  = 0;
   localparam int CMD_CHAN_BIT   = 8;
   localparam int CMD_DIR_BIT    = 9;
   localparam int ST_LOADED_BIT  = 8;
   localparam int ST_SYNCF_BIT   = 9;
   localparam int ST_BBUSED_BIT  = 10;
   localparam int ST_REJECT_BIT  = 11;

   localparam logic [7:0] DIRB_RESET = 8'h00;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] dat_oe;
      logic       txe_n;
      logic       rxf_n;
      logic       rd_oe;
      logic       wr_oe;
   } chb_pins_t;

endpackage

//--- logic/buf_owner.sv
// buffer-memory owner selector: channel b's buffer follows channel a in sync fifo
// assumes requests are synchronous to core_clk; grant and owner outputs are registered
`timescale 1ns/10ps
`default_nettype none
module buf_owner
   import mode_select_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       sync_fifo,
   input  wire logic       a_req,
   input  wire logic       b_req,
   output logic            b_grant_q,
   output logic            b_owner_a_q
);
   logic b_grant_d;
   logic b_owner_a_d;

   always_comb
   begin
      b_owner_a_d = sync_fifo;
      b_grant_d   = sync_fifo ? a_req : b_req;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         b_grant_q   <= 1'b0;
         b_owner_a_q <= 1'b0;
      end
      else
      begin
         b_grant_q   <= b_grant_d;
         b_owner_a_q <= b_owner_a_d;
      end
   end
endmodule
`default_nettype wire

//--- logic/mode_select.sv
// per-channel interface mode selector for a two-channel bridge
// assumes config words, enumeration and commands come from the usb core in core_clk domain
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - reset puts both channels in async serial
// - config memory load sets base mode
// - after enumeration command selects bang/engine modes
// - value 0x40 in fifo mode selects sync
// - sync fifo needs both channels in a fifo mode; a config load selecting sync on a forces b to async fifo whatever b's word
// - sync fifo gives channel b buffer to a
// - channel b pins keep state or default
// - direction command may float channel b pins
// - mode sources limited per table
module mode_select
   import mode_select_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        cfg_valid,
   input  wire logic [2:0]  cfg_mode_a,
   input  wire logic [2:0]  cfg_mode_b,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic        a_buf_req,
   input  wire logic        b_buf_req,
   output logic [31:0]      reg_rdata_q,
   output chan_mode_t       mode_a_q,
   output chan_mode_t       mode_b_q,
   output logic             b_buf_grant,
   output logic             b_buf_to_a,
   output chb_pins_t        chb_pins_q
);
   chan_mode_t mode_a_d, mode_b_d;
   logic       loaded_q, loaded_d;
   logic       enum_q, enum_d;
   logic       bused_q, bused_d;
   logic       reject_q, reject_d;
   logic [7:0] dirb_q, dirb_d;
   logic [31:0] rdata_d;
   chb_pins_t  pins_d;
   logic       sync_now;
   logic       cmd_wr;

   function automatic chan_mode_t cfg_decode(input logic [2:0] w);
      chan_mode_t m;
      m = MODE_ASYNC_SERIAL;
      unique case (w[1:0])
         CFG_ASYNC_SERIAL: m = MODE_ASYNC_SERIAL;
         CFG_ASYNC_FIFO:   m = w[CFG_SYNC_BIT] ? MODE_SYNC_FIFO : MODE_ASYNC_FIFO;
         CFG_CPU_FIFO:     m = MODE_CPU_FIFO;
         CFG_FAST_SERIAL:  m = MODE_FAST_SERIAL;
      endcase
      return m;
   endfunction

   function automatic logic is_fifo(input chan_mode_t m);
      return (m == MODE_ASYNC_FIFO) || (m == MODE_SYNC_FIFO);
   endfunction

   assign cmd_wr   = reg_wr && (reg_addr == REG_CMD);
   assign sync_now = (mode_a_q == MODE_SYNC_FIFO);

   always_comb
   begin
      logic [7:0] val;
      logic       chan;
      logic       ok;
      chan_mode_t base, nm;
      val      = reg_wdata[7:0];
      chan     = reg_wdata[CMD_CHAN_BIT];
      ok       = 1'b1;
      base     = chan ? mode_b_q : mode_a_q;
      nm       = base;
      mode_a_d = mode_a_q;
      mode_b_d = mode_b_q;
      loaded_d = loaded_q;
      enum_d   = enum_q;
      dirb_d   = dirb_q;
      reject_d = reject_q;
      bused_d  = bused_q | (b_buf_req & ~sync_now);
      if (reg_wr && reg_addr == REG_CTRL)
         enum_d = reg_wdata[CTRL_ENUM_BIT];
      if (reg_wr && reg_addr == REG_DIRB)
         dirb_d = reg_wdata[7:0];
      if (cfg_valid && !loaded_q)
      begin
         mode_a_d = cfg_decode(cfg_mode_a);
         mode_b_d = cfg_decode(cfg_mode_b);
         if (mode_a_d == MODE_SYNC_FIFO)
            mode_b_d = MODE_ASYNC_FIFO;
         loaded_d = 1'b1;
      end
      else if (cmd_wr && enum_q && loaded_q)
      begin
         if (reg_wdata[CMD_DIR_BIT])
         begin
            if (chan)
               dirb_d = val;
         end
         else
         begin
            unique case (val)
               CMD_ASYNC_BANG:   nm = MODE_ASYNC_BANG;
               CMD_SYNC_BANG:    nm = MODE_SYNC_BANG;
               CMD_SERIAL_ENG:   nm = MODE_SERIAL_ENG;
               CMD_HOST_BUS_EMU: nm = MODE_HOST_BUS_EMU;
               CMD_SYNC_FIFO:
                  // both channels must already sit in a fifo mode
                  if (!chan && is_fifo(mode_a_q) && is_fifo(mode_b_q))
                     nm = MODE_SYNC_FIFO;
                  else
                     ok = 1'b0;
               default:
                  nm = is_fifo(base) ? MODE_ASYNC_FIFO : base;
            endcase
            // channel b is unusable while channel a owns its buffer
            if (chan && sync_now)
               ok = 1'b0;
            reject_d = ~ok;
            if (ok)
            begin
               if (chan)
                  mode_b_d = nm;
               else
                  mode_a_d = nm;
            end
         end
      end
   end

   always_comb
   begin
      // unused channel b shows its default idle pin state
      pins_d.dat_oe = bused_q ? dirb_q : 8'h00;
      pins_d.txe_n  = 1'b0;
      pins_d.rxf_n  = 1'b1;
      pins_d.rd_oe  = 1'b0;
      pins_d.wr_oe  = 1'b0;
      if (sync_now)
         pins_d = chb_pins_q;
      // an idle channel b keeps its default pins; a one-cycle enable pulse there would glitch the bus
      if (cmd_wr && reg_wdata[CMD_DIR_BIT] && reg_wdata[CMD_CHAN_BIT] && enum_q && loaded_q
          && (bused_q || sync_now))
         pins_d.dat_oe = reg_wdata[7:0];
   end

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            REG_CTRL:   rdata_d[CTRL_ENUM_BIT] = enum_q;
            REG_STATUS:
            begin
               rdata_d[3:0] = mode_a_q;
               rdata_d[7:4] = mode_b_q;
               rdata_d[ST_LOADED_BIT] = loaded_q;
               rdata_d[ST_SYNCF_BIT]  = sync_now;
               rdata_d[ST_BBUSED_BIT] = bused_q;
               rdata_d[ST_REJECT_BIT] = reject_q;
            end
            REG_DIRB:   rdata_d[7:0] = dirb_q;
            default:    rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_a_q    <= MODE_ASYNC_SERIAL;
         mode_b_q    <= MODE_ASYNC_SERIAL;
         loaded_q    <= 1'b0;
         enum_q      <= 1'b0;
         bused_q     <= 1'b0;
         reject_q    <= 1'b0;
         dirb_q      <= DIRB_RESET;
         reg_rdata_q <= 32'h0000_0000;
         chb_pins_q  <= '{dat_oe: 8'h00, txe_n: 1'b0, rxf_n: 1'b1, rd_oe: 1'b0, wr_oe: 1'b0};
      end
      else
      begin
         mode_a_q    <= mode_a_d;
         mode_b_q    <= mode_b_d;
         loaded_q    <= loaded_d;
         enum_q      <= enum_d;
         bused_q     <= bused_d;
         reject_q    <= reject_d;
         dirb_q      <= dirb_d;
         reg_rdata_q <= rdata_d;
         chb_pins_q  <= pins_d;
      end
   end

   buf_owner u_buf_owner (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .sync_fifo   (sync_now),
      .a_req       (a_buf_req),
      .b_req       (b_buf_req),
      .b_grant_q   (b_buf_grant),
      .b_owner_a_q (b_buf_to_a)
   );

   AST_RESET_ASYNC_SERIAL: assert property (@(posedge core_clk) disable iff (!rst_n)
      !loaded_q |-> (mode_a_q == MODE_ASYNC_SERIAL && mode_b_q == MODE_ASYNC_SERIAL))
      else $error("mode left async serial before load");
   AST_LOAD_SETS_MODE: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cfg_valid && !loaded_q) |=> (loaded_q && mode_a_q == cfg_decode($past(cfg_mode_a))))
      else $error("config load did not set channel a mode");
   AST_CMD_NEEDS_ENUM: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cmd_wr && !enum_q && !cfg_valid) |=> $stable(mode_a_q) && $stable(mode_b_q))
      else $error("mode changed by command before enumeration");
   AST_SYNC_FIFO_ENTRY: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cmd_wr && enum_q && loaded_q && !cfg_valid && reg_wdata[9:0] == 10'h040
       && mode_a_q == MODE_ASYNC_FIFO && mode_b_q == MODE_ASYNC_FIFO) |=> sync_now)
      else $error("0x40 did not select sync fifo");
   AST_SYNC_NEEDS_FIFO: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($rose(sync_now) && $past(loaded_q)) |-> $past(is_fifo(mode_b_q)))
      else $error("sync fifo entered without channel b in fifo mode");
   AST_B_BUF_TO_A: assert property (@(posedge core_clk) disable iff (!rst_n)
      sync_now |=> (b_buf_to_a && b_buf_grant == $past(a_buf_req)))
      else $error("channel b buffer not handed to channel a");
   AST_B_PINS_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      (sync_now && !cmd_wr) |=> $stable(chb_pins_q))
      else $error("channel b pins moved during sync fifo");
   AST_B_DEFAULT_PINS: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!bused_q && !sync_now) |=> (chb_pins_q.dat_oe == 8'h00 && chb_pins_q.rxf_n))
      else $error("unused channel b pins not in default state");
   AST_MODE_ONLY_BY_SOURCE: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!cfg_valid && !cmd_wr) |=> $stable(mode_a_q) && $stable(mode_b_q))
      else $error("mode changed without a source");
endmodule
`default_nettype wire

//--- verif/cfg_mem_model.sv
// behavioural configuration memory: hands both base-mode words over once after each reset
// assumes core_clk domain; the bench sets the words before reset is released
`timescale 1ns/10ps
`default_nettype none
module cfg_mem_model
#(
   parameter int LOAD_DELAY = 20
)
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] word_a,
   input  wire logic [2:0] word_b,
   output logic            cfg_valid,
   output logic [2:0]      cfg_mode_a,
   output logic [2:0]      cfg_mode_b
);
   int cnt;
   // outside the one-cycle burst the lines carry the inverse, so stale data cannot pass for a load
   always @(posedge core_clk or negedge rst_n)
      if (!rst_n)
      begin
         cnt        <= 0;
         cfg_valid  <= 1'b0;
         cfg_mode_a <= ~word_a;
         cfg_mode_b <= ~word_b;
      end
      else
      begin
         cnt        <= cnt + 1;
         cfg_valid  <= (cnt == LOAD_DELAY);
         cfg_mode_a <= (cnt == LOAD_DELAY) ? word_a : ~word_a;
         cfg_mode_b <= (cnt == LOAD_DELAY) ? word_b : ~word_b;
      end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the channel mode selector
// assumes the design carries its own assertions; one 125 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import mode_select_pkg::*;
;
   typedef struct {logic [2:0] ca; logic [2:0] cb; logic ch; logic [7:0] val; chan_mode_t ea; chan_mode_t eb;} row_t;
   logic        core_clk, rst_n, reg_wr, reg_rd, a_buf_req, b_buf_req, cfg_valid;
   logic [2:0]  word_a, word_b, cfg_mode_a, cfg_mode_b;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata_q, rd_q;
   chan_mode_t  mode_a_q, mode_b_q;
   chb_pins_t   chb_pins_q;
   logic        b_buf_grant, b_buf_to_a;
   int          n_fail = 0, checks = 0, cyc = 0;
   row_t rows [9] = '{
      '{3'h1, 3'h1, 1'b0, CMD_SYNC_FIFO, MODE_SYNC_FIFO, MODE_ASYNC_FIFO},
      '{3'h1, 3'h0, 1'b0, CMD_SYNC_FIFO, MODE_ASYNC_FIFO, MODE_ASYNC_SERIAL},
      '{3'h0, 3'h1, 1'b1, CMD_ASYNC_BANG, MODE_ASYNC_SERIAL, MODE_ASYNC_BANG},
      '{3'h2, 3'h3, 1'b1, CMD_SYNC_BANG, MODE_CPU_FIFO, MODE_SYNC_BANG},
      '{3'h3, 3'h2, 1'b0, CMD_RESET_MODE, MODE_FAST_SERIAL, MODE_CPU_FIFO},
      '{3'h1, 3'h1, 1'b0, CMD_HOST_BUS_EMU, MODE_HOST_BUS_EMU, MODE_ASYNC_FIFO},
      '{3'h5, 3'h0, 1'b1, CMD_ASYNC_BANG, MODE_SYNC_FIFO, MODE_ASYNC_FIFO},
      '{3'h1, 3'h1, 1'b0, 8'h10, MODE_ASYNC_FIFO, MODE_ASYNC_FIFO},
      '{3'h0, 3'h0, 1'b0, CMD_SERIAL_ENG, MODE_SERIAL_ENG, MODE_ASYNC_SERIAL}};

   cfg_mem_model #(.LOAD_DELAY(20)) cfg_mem (.core_clk(core_clk), .rst_n(rst_n), .word_a(word_a),
      .word_b(word_b), .cfg_valid(cfg_valid), .cfg_mode_a(cfg_mode_a), .cfg_mode_b(cfg_mode_b));
   mode_select dut (.core_clk(core_clk), .rst_n(rst_n), .cfg_valid(cfg_valid), .cfg_mode_a(cfg_mode_a),
      .cfg_mode_b(cfg_mode_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .a_buf_req(a_buf_req), .b_buf_req(b_buf_req), .reg_rdata_q(reg_rdata_q), .mode_a_q(mode_a_q),
      .mode_b_q(mode_b_q), .b_buf_grant(b_buf_grant), .b_buf_to_a(b_buf_to_a), .chb_pins_q(chb_pins_q));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // the whole run needs well under a thousand cycles
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         test_done();
      end
   end

   task automatic chk_mode(input string what, input chan_mode_t exp, input chan_mode_t got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bits(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 rd_q = reg_rdata_q;
   endtask

   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   // reset, let the memory load, then mark the device enumerated
   task automatic boot(input logic [2:0] a, input logic [2:0] b);
      @(posedge core_clk);
      word_a <= a;
      word_b <= b;
      rst_n  <= 1'b0;
      repeat (6) @(posedge core_clk);
      rst_n  <= 1'b1;
      repeat (26) @(posedge core_clk);
      reg_write(REG_CTRL, 32'h1);
   endtask

   initial
   begin
      {rst_n, reg_wr, reg_rd, a_buf_req, b_buf_req, reg_addr, reg_wdata, word_a, word_b} = '0;
      repeat (6) @(posedge core_clk);
      #1;
      chk_mode("mode_a", MODE_ASYNC_SERIAL, mode_a_q);
      chk_mode("mode_b", MODE_ASYNC_SERIAL, mode_b_q);
      chk_bits("chb_pins", 32'h004, {20'h0, chb_pins_q});
      @(posedge core_clk);
      rst_n <= 1'b1;
      reg_write(REG_CMD, {24'h0, CMD_ASYNC_BANG});
      reg_write(REG_CTRL, 32'h1);
      settle();
      chk_mode("early_cmd", MODE_ASYNC_SERIAL, mode_a_q);
      reg_read(4'h1);
      chk_bits("unmapped", 32'h0, rd_q);
      reg_read(REG_DIRB);
      chk_bits("dirb_reset", {24'h0, DIRB_RESET}, rd_q);
      foreach (rows[i])
      begin
         boot(rows[i].ca, rows[i].cb);
         reg_write(REG_CMD, {23'h0, rows[i].ch, rows[i].val});
         settle();
         chk_mode("mode_a", rows[i].ea, mode_a_q);
         chk_mode("mode_b", rows[i].eb, mode_b_q);
      end
      boot(3'h1, 3'h1);
      reg_write(REG_CMD, {22'h0, 2'b11, 8'h0f});
      settle();
      chk_bits("dat_oe_idle", 32'h00, {24'h0, chb_pins_q.dat_oe});
      reg_read(REG_DIRB);
      chk_bits("dirb", 32'h0f, rd_q);
      @(posedge core_clk);
      b_buf_req <= 1'b1;
      @(posedge core_clk);
      b_buf_req <= 1'b0;
      settle();
      chk_bits("dat_oe_used", 32'h0f, {24'h0, chb_pins_q.dat_oe});
      reg_write(REG_CMD, {22'h0, 2'b11, 8'h00});
      reg_write(REG_CMD, {24'h0, CMD_SYNC_FIFO});
      a_buf_req <= 1'b1;
      settle();
      chk_bits("chb_pins", 32'h004, {20'h0, chb_pins_q});
      chk_bits("buf_to_a", 32'h1, {31'h0, b_buf_to_a});
      chk_bits("grant", 32'h1, {31'h0, b_buf_grant});
      reg_read(REG_STATUS);
      chk_bits("status", 32'h312, rd_q & 32'h3ff);
      reg_write(REG_CMD, {23'h0, 1'b1, CMD_ASYNC_BANG});
      reg_read(REG_STATUS);
      chk_bits("reject", 32'h1, {31'h0, rd_q[ST_REJECT_BIT]});
      chk_mode("mode_b", MODE_ASYNC_FIFO, mode_b_q);
      reg_write(REG_CMD, {24'h0, CMD_RESET_MODE});
      repeat (3) @(posedge core_clk);
      #1;
      chk_mode("mode_a", MODE_ASYNC_FIFO, mode_a_q);
      chk_bits("buf_to_a", 32'h0, {31'h0, b_buf_to_a});
      chk_bits("grant", 32'h0, {31'h0, b_buf_grant});
      test_done();
   end
endmodule
`default_nettype wire
